// ### shared/done_irq_map.svh
`ifndef DONE_IRQ_MAP_SVH
`define DONE_IRQ_MAP_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFF_DONE_IRQ_ENABLE 12'h314
`define OFF_TIMED_STREAM_OR_GROUP_MASK 12'h318
`define OFF_PERIODIC_POLL_OR_GROUP_MASK 12'h31C
`define OFF_ASYNC_LIST_OR_GROUP_MASK 12'h320
`define OFF_TIMED_STREAM_AND_GROUP_MASK 12'h324
`define OFF_PERIODIC_POLL_AND_GROUP_MASK 12'h328
`define OFF_ASYNC_LIST_AND_GROUP_MASK 12'h32C
`define OFF_GROUP_STATUS 12'h330

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_GROUP_MASK 32'h00000000
`define RST_DONE_IRQ_ENABLE 32'h00000000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_TIMED_STREAM_DONE_IRQ_ENABLE 9
`define BIT_ASYNC_LIST_DONE_IRQ_ENABLE 8
`define BIT_PERIODIC_POLL_DONE_IRQ_ENABLE 7
`define WRITABLE_DONE_IRQ_ENABLE 32'h00000380
`define WRITABLE_GROUP_MASK 32'hFFFFFFFF
`define STATUS_OR_MET_LSB 0
`define STATUS_AND_MET_LSB 4
`define STATUS_EVENT_LSB 8

// ------------------------------------------------------------
// Bus responses
// ------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### shared/done_irq_pkg.sv
`default_nettype none
package done_irq_pkg;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_type;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_type;

  // Schedule index order used for every three-wide vector
  typedef enum logic [1:0] {
    SCHED_TIMED_STREAM = 2'h0,
    SCHED_PERIODIC_POLL = 2'h1,
    SCHED_ASYNC_LIST = 2'h2
  } schedule_type;

endpackage

`default_nettype wire

// ### verilog/mask_reg.sv
`timescale 1ns/1ns
`default_nettype none

module mask_reg #(
  parameter int WIDTH = 32,
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITABLE = 32'hFFFFFFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH/8-1:0] wstrb,
  output logic [WIDTH-1:0] value_ff
);

  generate
    if (WIDTH != 32) begin : g_bad_width
      $error("mask_reg serves only 32-bit words");
    end
  endgenerate

  logic [WIDTH-1:0] nxt_value_ff;

  // Byte lanes without a strobe keep their old value; fixed bits stay zero
  always_comb begin
    nxt_value_ff = value_ff;
    for (int b = 0; b < WIDTH / 8; b++) begin
      if (wr_en && wstrb[b]) begin
        nxt_value_ff[b*8 +: 8] = wdata[b*8 +: 8] & WRITABLE[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_ff <= RESET_VALUE[WIDTH-1:0];
    end else if (clk_en) begin
      value_ff <= nxt_value_ff;
    end
  end

endmodule // mask_reg

`default_nettype wire

// ### verilog/group_match.sv
`timescale 1ns/1ns
`default_nettype none

module group_match #(
  parameter int DESC_COUNT = 32
) (
  input wire logic [DESC_COUNT-1:0] or_mask,
  input wire logic [DESC_COUNT-1:0] and_mask,
  input wire logic [DESC_COUNT-1:0] done_map,
  input wire logic enable,
  output logic or_met,
  output logic and_met,
  output logic event_req
);

  always_comb begin
    // Bit n of either mask looks only at transfer_descriptor n
    // A cleared OR bit drops out, so an all-zero mask never fires
    or_met = |(or_mask & done_map);
    // One AND over every selected descriptor; empty mask defines none
    and_met = (|and_mask) && ((and_mask & done_map) == and_mask);
    // Enable gates both conditions of this schedule
    event_req = enable && (or_met || and_met);
  end

endmodule // group_match

`default_nettype wire

// ### verilog/done_irq_grouping.sv
`timescale 1ns/1ns
`default_nettype none
`include "done_irq_map.svh"

// Contract
// - Timed stream OR mask at 0x318, reset zero
// - Periodic poll OR mask at 0x31C, reset zero
// - Async list OR mask at 0x320, reset zero
// - Timed stream AND mask at 0x324, reset zero
// - Periodic poll AND mask at 0x328, reset zero
// - Async list AND mask at 0x32C, reset zero
// - OR bit n selects descriptor n
// - Cleared OR bit excludes; zero mask no condition
// - AND bit n selects descriptor n
// - Async AND spans all 32 selected descriptors
// - Enable bits 9, 8, 7 gate each schedule
// - Done flag true means descriptor completed
module done_irq_grouping #(
  parameter int ADDR_WIDTH = 12,
  parameter int DESC_COUNT = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [DESC_COUNT-1:0] timed_stream_done_map,
  input wire logic [DESC_COUNT-1:0] periodic_poll_done_map,
  input wire logic [DESC_COUNT-1:0] async_list_done_map,
  output logic timed_stream_done_irq,
  output logic periodic_poll_done_irq,
  output logic async_list_done_irq
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  generate
    if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_addr
      $error("ADDR_WIDTH must lie in 12..32 to reach the register window");
    end
    if (DESC_COUNT != 32) begin : g_bad_count
      $error("DESC_COUNT must match the 32-bit mask registers");
    end
  endgenerate

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  done_irq_pkg::wr_state_type wr_state_ff;
  done_irq_pkg::wr_state_type nxt_wr_state_ff;
  done_irq_pkg::rd_state_type rd_state_ff;
  done_irq_pkg::rd_state_type nxt_rd_state_ff;

  logic aw_held_ff;
  logic nxt_aw_held_ff;
  logic w_held_ff;
  logic nxt_w_held_ff;
  logic [ADDR_WIDTH-1:0] waddr_ff;
  logic [ADDR_WIDTH-1:0] nxt_waddr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata_ff;
  logic [3:0] wstrb_ff;
  logic [3:0] nxt_wstrb_ff;
  logic awready_ff;
  logic nxt_awready_ff;
  logic wready_ff;
  logic nxt_wready_ff;
  logic bvalid_ff;
  logic nxt_bvalid_ff;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp_ff;
  logic arready_ff;
  logic nxt_arready_ff;
  logic rvalid_ff;
  logic nxt_rvalid_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata_ff;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp_ff;
  logic [2:0] irq_ff;
  logic [2:0] nxt_irq_ff;

  logic do_write;
  logic [6:0] reg_wr_en;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_value;

  logic [31:0] enable_reg;
  logic [31:0] ts_or_mask;
  logic [31:0] pp_or_mask;
  logic [31:0] al_or_mask;
  logic [31:0] ts_and_mask;
  logic [31:0] pp_and_mask;
  logic [31:0] al_and_mask;

  logic [2:0] or_met;
  logic [2:0] and_met;
  logic [2:0] event_req;
  logic [2:0] sched_enable;

  // ------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ------------------------------------------------------------
  always_comb begin
    nxt_wr_state_ff = wr_state_ff;
    nxt_aw_held_ff = aw_held_ff;
    nxt_w_held_ff = w_held_ff;
    nxt_waddr_ff = waddr_ff;
    nxt_wdata_ff = wdata_ff;
    nxt_wstrb_ff = wstrb_ff;
    nxt_bvalid_ff = bvalid_ff;
    nxt_bresp_ff = bresp_ff;
    do_write = 1'b0;
    case (wr_state_ff)
      done_irq_pkg::WR_COLLECT: begin
        if (awvalid && awready_ff) begin
          nxt_aw_held_ff = 1'b1;
          nxt_waddr_ff = awaddr;
        end
        if (wvalid && wready_ff) begin
          nxt_w_held_ff = 1'b1;
          nxt_wdata_ff = wdata;
          nxt_wstrb_ff = wstrb;
        end
        if (aw_held_ff && w_held_ff) begin
          do_write = 1'b1;
          nxt_aw_held_ff = 1'b0;
          nxt_w_held_ff = 1'b0;
          nxt_bvalid_ff = 1'b1;
          nxt_bresp_ff = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
          nxt_wr_state_ff = done_irq_pkg::WR_RESP;
        end
      end
      done_irq_pkg::WR_RESP: begin
        if (bready) begin
          nxt_bvalid_ff = 1'b0;
          nxt_bresp_ff = `RESP_OKAY;
          nxt_wr_state_ff = done_irq_pkg::WR_COLLECT;
        end
      end
      default: begin
        nxt_wr_state_ff = done_irq_pkg::WR_COLLECT;
        nxt_bvalid_ff = 1'b0;
      end
    endcase
    // Ready drops once a half is held so a second item cannot overwrite it
    nxt_awready_ff = !nxt_aw_held_ff && (nxt_wr_state_ff == done_irq_pkg::WR_COLLECT);
    nxt_wready_ff = !nxt_w_held_ff && (nxt_wr_state_ff == done_irq_pkg::WR_COLLECT);
  end

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  always_comb begin
    reg_wr_en = 7'h00;
    wr_hit = 1'b1;
    case (waddr_ff)
      ADDR_WIDTH'(`OFF_DONE_IRQ_ENABLE): reg_wr_en[6] = do_write;
      ADDR_WIDTH'(`OFF_TIMED_STREAM_OR_GROUP_MASK): reg_wr_en[0] = do_write;
      ADDR_WIDTH'(`OFF_PERIODIC_POLL_OR_GROUP_MASK): reg_wr_en[1] = do_write;
      ADDR_WIDTH'(`OFF_ASYNC_LIST_OR_GROUP_MASK): reg_wr_en[2] = do_write;
      ADDR_WIDTH'(`OFF_TIMED_STREAM_AND_GROUP_MASK): reg_wr_en[3] = do_write;
      ADDR_WIDTH'(`OFF_PERIODIC_POLL_AND_GROUP_MASK): reg_wr_en[4] = do_write;
      ADDR_WIDTH'(`OFF_ASYNC_LIST_AND_GROUP_MASK): reg_wr_en[5] = do_write;
      // Status is read-only: a write there is refused like a hole
      default: wr_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  mask_reg #(
    .WIDTH(32),
    .RESET_VALUE(`RST_DONE_IRQ_ENABLE),
    .WRITABLE(`WRITABLE_DONE_IRQ_ENABLE)
  ) u_enable_reg (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .wr_en(reg_wr_en[6]),
    .wdata(wdata_ff),
    .wstrb(wstrb_ff),
    .value_ff(enable_reg)
  );

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_ts_or (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[0]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(ts_or_mask));

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_pp_or (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[1]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(pp_or_mask));

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_al_or (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[2]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(al_or_mask));

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_ts_and (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[3]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(ts_and_mask));

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_pp_and (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[4]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(pp_and_mask));

  mask_reg #(.WIDTH(32), .RESET_VALUE(`RST_GROUP_MASK), .WRITABLE(`WRITABLE_GROUP_MASK))
  u_al_and (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .wr_en(reg_wr_en[5]),
    .wdata(wdata_ff), .wstrb(wstrb_ff), .value_ff(al_and_mask));

  // ------------------------------------------------------------
  // Grouping per schedule
  // ------------------------------------------------------------
  always_comb begin
    sched_enable[done_irq_pkg::SCHED_TIMED_STREAM] =
      enable_reg[`BIT_TIMED_STREAM_DONE_IRQ_ENABLE];
    sched_enable[done_irq_pkg::SCHED_PERIODIC_POLL] =
      enable_reg[`BIT_PERIODIC_POLL_DONE_IRQ_ENABLE];
    sched_enable[done_irq_pkg::SCHED_ASYNC_LIST] =
      enable_reg[`BIT_ASYNC_LIST_DONE_IRQ_ENABLE];
  end

  // Done maps arrive as levels already reflecting each descriptor's done flag
  group_match #(.DESC_COUNT(DESC_COUNT)) u_ts_match (
    .or_mask(ts_or_mask),
    .and_mask(ts_and_mask),
    .done_map(timed_stream_done_map),
    .enable(sched_enable[0]),
    .or_met(or_met[0]),
    .and_met(and_met[0]),
    .event_req(event_req[0])
  );

  group_match #(.DESC_COUNT(DESC_COUNT)) u_pp_match (
    .or_mask(pp_or_mask),
    .and_mask(pp_and_mask),
    .done_map(periodic_poll_done_map),
    .enable(sched_enable[1]),
    .or_met(or_met[1]),
    .and_met(and_met[1]),
    .event_req(event_req[1])
  );

  group_match #(.DESC_COUNT(DESC_COUNT)) u_al_match (
    .or_mask(al_or_mask),
    .and_mask(al_and_mask),
    .done_map(async_list_done_map),
    .enable(sched_enable[2]),
    .or_met(or_met[2]),
    .and_met(and_met[2]),
    .event_req(event_req[2])
  );

  // Level follows the condition; clearing a done flag or mask drops it
  always_comb begin
    nxt_irq_ff = event_req;
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_value = 32'h00000000;
    case (araddr)
      ADDR_WIDTH'(`OFF_DONE_IRQ_ENABLE): rd_value = enable_reg;
      ADDR_WIDTH'(`OFF_TIMED_STREAM_OR_GROUP_MASK): rd_value = ts_or_mask;
      ADDR_WIDTH'(`OFF_PERIODIC_POLL_OR_GROUP_MASK): rd_value = pp_or_mask;
      ADDR_WIDTH'(`OFF_ASYNC_LIST_OR_GROUP_MASK): rd_value = al_or_mask;
      ADDR_WIDTH'(`OFF_TIMED_STREAM_AND_GROUP_MASK): rd_value = ts_and_mask;
      ADDR_WIDTH'(`OFF_PERIODIC_POLL_AND_GROUP_MASK): rd_value = pp_and_mask;
      ADDR_WIDTH'(`OFF_ASYNC_LIST_AND_GROUP_MASK): rd_value = al_and_mask;
      ADDR_WIDTH'(`OFF_GROUP_STATUS): begin
        rd_value[`STATUS_OR_MET_LSB +: 3] = or_met;
        rd_value[`STATUS_AND_MET_LSB +: 3] = and_met;
        rd_value[`STATUS_EVENT_LSB +: 3] = irq_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_rd_state_ff = rd_state_ff;
    nxt_arready_ff = arready_ff;
    nxt_rvalid_ff = rvalid_ff;
    nxt_rdata_ff = rdata_ff;
    nxt_rresp_ff = rresp_ff;
    case (rd_state_ff)
      done_irq_pkg::RD_IDLE: begin
        // Ready comes up one cycle after reset so no beat is taken during it
        nxt_arready_ff = 1'b1;
        if (arvalid && arready_ff) begin
          nxt_arready_ff = 1'b0;
          nxt_rvalid_ff = 1'b1;
          nxt_rdata_ff = rd_value;
          nxt_rresp_ff = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
          nxt_rd_state_ff = done_irq_pkg::RD_RESP;
        end
      end
      done_irq_pkg::RD_RESP: begin
        if (rready) begin
          nxt_arready_ff = 1'b1;
          nxt_rvalid_ff = 1'b0;
          nxt_rdata_ff = 32'h00000000;
          nxt_rresp_ff = `RESP_OKAY;
          nxt_rd_state_ff = done_irq_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_rd_state_ff = done_irq_pkg::RD_IDLE;
        nxt_arready_ff = 1'b1;
        nxt_rvalid_ff = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= done_irq_pkg::WR_COLLECT;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      rd_state_ff <= done_irq_pkg::RD_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
      irq_ff <= 3'h0;
    end else if (clk_en) begin
      wr_state_ff <= nxt_wr_state_ff;
      aw_held_ff <= nxt_aw_held_ff;
      w_held_ff <= nxt_w_held_ff;
      waddr_ff <= nxt_waddr_ff;
      wdata_ff <= nxt_wdata_ff;
      wstrb_ff <= nxt_wstrb_ff;
      awready_ff <= nxt_awready_ff;
      wready_ff <= nxt_wready_ff;
      bvalid_ff <= nxt_bvalid_ff;
      bresp_ff <= nxt_bresp_ff;
      rd_state_ff <= nxt_rd_state_ff;
      arready_ff <= nxt_arready_ff;
      rvalid_ff <= nxt_rvalid_ff;
      rdata_ff <= nxt_rdata_ff;
      rresp_ff <= nxt_rresp_ff;
      irq_ff <= nxt_irq_ff;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign timed_stream_done_irq = irq_ff[0];
  assign periodic_poll_done_irq = irq_ff[1];
  assign async_list_done_irq = irq_ff[2];

endmodule // done_irq_grouping

`default_nettype wire

// ### verif/irq_grouping_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checker for the done grouping block
// ------------------------------------------------------------
module irq_grouping_checker #(
  parameter int DESC_COUNT = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [DESC_COUNT-1:0] timed_stream_done_map,
  input wire logic [DESC_COUNT-1:0] periodic_poll_done_map,
  input wire logic [DESC_COUNT-1:0] async_list_done_map,
  input wire logic timed_stream_done_irq,
  input wire logic periodic_poll_done_irq,
  input wire logic async_list_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // An irq can only rise when some descriptor of that schedule was done
  a_ts_irq_cause: assert property ($rose(timed_stream_done_irq) |->
    $past(timed_stream_done_map) != '0) else $error("timed irq without done");
  a_pp_irq_cause: assert property ($rose(periodic_poll_done_irq) |->
    $past(periodic_poll_done_map) != '0) else $error("periodic irq without done");
  a_al_irq_cause: assert property ($rose(async_list_done_irq) |->
    $past(async_list_done_map) != '0) else $error("async irq without done");
  a_idle_map_quiet: assert property (clk_en && timed_stream_done_map == '0 &&
    periodic_poll_done_map == '0 && async_list_done_map == '0 |=>
    !(timed_stream_done_irq || periodic_poll_done_irq || async_list_done_irq))
    else $error("irq with empty done maps");
  a_reset_irq_low: assert property (disable iff (1'b0) !aresetn |=>
    !(timed_stream_done_irq || periodic_poll_done_irq || async_list_done_irq))
    else $error("irq high after reset");
  a_frozen_irq_stable: assert property (!clk_en |=>
    $stable({timed_stream_done_irq, periodic_poll_done_irq, async_list_done_irq}))
    else $error("irq moved while frozen");
  a_bresp_holds: assert property (bvalid && !(bready && clk_en) |=> bvalid)
    else $error("write response dropped early");
  a_rdata_holds: assert property (rvalid && !(rready && clk_en) |=> rvalid)
    else $error("read response dropped early");
  a_read_answer: assert property (arvalid && arready && clk_en |=> rvalid)
    else $error("read not answered next cycle");
endmodule // irq_grouping_checker

bind done_irq_grouping irq_grouping_checker #(.DESC_COUNT(DESC_COUNT)) chk (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .bvalid(bvalid), .bready(bready),
  .timed_stream_done_map(timed_stream_done_map),
  .periodic_poll_done_map(periodic_poll_done_map),
  .async_list_done_map(async_list_done_map),
  .timed_stream_done_irq(timed_stream_done_irq),
  .periodic_poll_done_irq(periodic_poll_done_irq),
  .async_list_done_irq(async_list_done_irq)
);
`default_nettype wire

// ### verif/axil_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Software side: one AXI4-Lite access at a time
// ------------------------------------------------------------
module axil_host (
  input wire logic aclk,
  input wire logic clk_en,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // A frozen edge moves nothing, so handshakes only count with clk_en
  task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (clk_en && !aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (clk_en && !w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!(clk_en && bvalid));
    bready <= 1'b0;
  endtask
  task automatic read(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!(clk_en && arready));
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!(clk_en && rvalid));
    rready <= 1'b0;
  endtask
endmodule // axil_host
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb;
  logic aclk = 0, aresetn = 0, clk_en = 1, irq_req = 0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] map [3] = '{default: '0};
  logic [2:0] irq;
  int fail_count = 0, n_checks = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [2:0] iq[$];
  logic [11:0] regs [7] = '{12'h318, 12'h31C, 12'h320, 12'h324, 12'h328, 12'h32C, 12'h314};
  int ebit [3] = '{9, 7, 8};
  always #5 aclk = ~aclk;
  done_irq_grouping dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timed_stream_done_map(map[0]), .periodic_poll_done_map(map[1]),
    .async_list_done_map(map[2]), .timed_stream_done_irq(irq[0]),
    .periodic_poll_done_irq(irq[1]), .async_list_done_irq(irq[2]));
  axil_host host (.aclk(aclk), .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready));
  // ------------------------------------------------------------
  // Comparison and verdict
  // ------------------------------------------------------------
  task check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (clk_en && rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
    if (clk_en && bvalid && bready) check("bresp", 34'(bresp), 34'(bq.pop_front()));
  end
  // Irq is a level; sample it mid-cycle once the launching edge has landed
  always @(negedge aclk) if (irq_req) check("irq", 34'(irq), 34'(iq.pop_front()));
  // ------------------------------------------------------------
  // Access helpers
  // ------------------------------------------------------------
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    host.read(a);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    host.write(a, d, 4'hF);
  endtask
  task irq_expect(input logic [2:0] e);
    @(posedge aclk);
    irq_req <= 1'b1;
    iq.push_back(e);
    @(posedge aclk);
    irq_req <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  initial begin
    logic [31:0] v, om, am, noise;
    logic [2:0] hit;
    void'($urandom(35672));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(regs[i], 32'h00000000, 2'h0);
    // One byte lane only: the other lanes keep their reset value
    bq.push_back(2'h0);
    host.write(12'h318, 32'hA5A5A5A5, 4'h2);
    rd(12'h318, 32'h0000A500, 2'h0);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(regs[i], v, 2'h0);
      rd(regs[i], v, 2'h0);
    end
    wr(12'h33C, 32'h12345678, 2'h2);
    rd(12'h33C, 32'h00000000, 2'h2);
    wr(12'h330, 32'hFFFFFFFF, 2'h2);
    wr(12'h314, 32'hFFFFFFFF, 2'h0);
    rd(12'h314, 32'h00000380, 2'h0);
    for (int s = 0; s < 3; s++) begin
      om = 32'h1 << ($urandom % 10);
      am = (32'h1 << (10 + $urandom % 10)) | (32'h1 << (20 + $urandom % 12));
      noise = $urandom & ~(om | am);
      hit = 3'(32'h1 << s);
      wr(12'h318 + 12'(4 * s), om, 2'h0);
      wr(12'h324 + 12'(4 * s), am, 2'h0);
      map[s] <= noise;
      irq_expect(3'h0);
      map[s] <= (am & (am - 32'h1)) | noise;
      irq_expect(3'h0);
      map[s] <= om | noise;
      irq_expect(hit);
      rd(12'h330, 32'(hit) | (32'(hit) << 8), 2'h0);
      clk_en <= 1'b0;
      map[s] <= 32'h00000000;
      irq_expect(hit);
      clk_en <= 1'b1;
      map[s] <= am | noise;
      irq_expect(hit);
      wr(12'h314, 32'h00000380 & ~(32'h1 << ebit[s]), 2'h0);
      irq_expect(3'h0);
      wr(12'h314, 32'h00000380, 2'h0);
      map[s] <= 32'h00000000;
    end
    summarize();
  end
endmodule // tb
`default_nettype wire
